// ==== include/cpuax_params.svh ====
`ifndef CPUAX_PARAMS_SVH
`define CPUAX_PARAMS_SVH

// address shape: 4-bit bank over a 16-bit byte address
`define CPUAX_ADDR_W 20
`define CPUAX_BANK_W 4
`define CPUAX_OFS_W 16
`define CPUAX_NBANK 6
`define CPUAX_BANK_RST 4'h0

// operand sizes in bits
`define CPUAX_BYTE_W 8
`define CPUAX_WORD_W 16
`define CPUAX_LONG_W 32
`define CPUAX_FIX_W 36

// sign and radix positions of the fractional formats
`define CPUAX_F16_SIGN 15
`define CPUAX_F32_SIGN 31
`define CPUAX_FIX_SIGN 35
`define CPUAX_FIX_EXT_LO 31
`define CPUAX_F16_MIN 16'h8000
`define CPUAX_F32_MIN 32'h8000_0000
`define CPUAX_FIX_MIN 36'h8_0000_0000

// largest legal packed decimal digit
`define CPUAX_BCD_MAX 4'h9

`endif

// ==== include/cpuax_pkg.sv ====
`include "cpuax_params.svh"

package cpuax_pkg;

	// access type, one per bank extension field
	typedef enum logic [2:0] {
		BK_EXT = 3'h0,
		BK_X = 3'h1,
		BK_Y = 3'h2,
		BK_Z = 3'h3,
		BK_PC = 3'h4,
		BK_SP = 3'h5
	} cpuax_kind_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} cpuax_size_t;

	// operation class, decides operand size legality and marks fetches
	typedef enum logic [2:0] {
		OP_PLAIN = 3'h0,
		OP_BITSC = 3'h1,
		OP_BITTST = 3'h2,
		OP_BCD = 3'h3,
		OP_MACOFF = 3'h4,
		OP_LONG = 3'h5,
		OP_FETCH = 3'h6
	} cpuax_op_t;

	typedef enum logic [2:0] {
		FM_INT8 = 3'h0,
		FM_INT16 = 3'h1,
		FM_FRAC16 = 3'h2,
		FM_FRAC32 = 3'h3,
		FM_FIX36 = 3'h4,
		FM_BCD = 3'h5,
		FM_NIB = 3'h6
	} cpuax_fmt_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUS = 3'b010,
		ST_SPARE = 3'b100
	} cpuax_state_t;

	typedef struct packed {
		cpuax_state_t st;
		logic [`CPUAX_ADDR_W-1:0] addr;
		logic [2:0] left;
		logic [`CPUAX_LONG_W-1:0] acc;
		logic [`CPUAX_LONG_W-1:0] wdat;
		logic wr;
		logic fetch;
		logic [`CPUAX_NBANK-1:0][`CPUAX_BANK_W-1:0] banks;
		logic [`CPUAX_ADDR_W-1:0] bus_addr;
		logic bus_byte;
		logic bus_rd;
		logic bus_wr;
		logic [`CPUAX_WORD_W-1:0] bus_wdata;
		logic req_ready;
		logic rsp_valid;
		logic rsp_err;
		logic [`CPUAX_LONG_W-1:0] rsp_rdata;
		logic chk_sign;
		logic chk_bad;
		logic chk_min;
	} cpuax_regs_t;

endpackage

// ==== rtl/cpuax_fmt.sv ====
`include "cpuax_params.svh"

// decodes the sign, range and validity of one operand in a named format
module cpuax_fmt (
	input wire cpuax_pkg::cpuax_fmt_t fmt, // format of value
	input wire logic [`CPUAX_FIX_W-1:0] value, // operand, low aligned
	output logic sign, // operand is negative
	output logic bad, // digit out of range or extension bits in use
	output logic is_min // operand is the most negative fraction or fixed point code
);

	// pure decode, registered by the caller
	always_comb
	begin
		sign = 1'b0;
		bad = 1'b0;
		is_min = 1'b0;
		case (fmt)
			cpuax_pkg::FM_INT8:
			begin
				sign = value[`CPUAX_BYTE_W-1];
			end
			cpuax_pkg::FM_INT16:
			begin
				sign = value[`CPUAX_WORD_W-1];
			end
			cpuax_pkg::FM_FRAC16:
			begin
				// radix point sits between bits 15 and 14
				sign = value[`CPUAX_F16_SIGN];
				is_min = value[`CPUAX_WORD_W-1:0] == `CPUAX_F16_MIN;
			end
			cpuax_pkg::FM_FRAC32:
			begin
				sign = value[`CPUAX_F32_SIGN];
				is_min = value[`CPUAX_LONG_W-1:0] == `CPUAX_F32_MIN;
			end
			cpuax_pkg::FM_FIX36:
			begin
				// bad flags a magnitude outside -1..1 held in the extension bits
				sign = value[`CPUAX_FIX_SIGN];
				bad = value[`CPUAX_FIX_SIGN:`CPUAX_FIX_EXT_LO] != {5{value[`CPUAX_FIX_SIGN]}};
				is_min = value == `CPUAX_FIX_MIN;
			end
			cpuax_pkg::FM_BCD:
			begin
				// two packed digits, each 0 to 9
				bad = (value[7:4] > `CPUAX_BCD_MAX) || (value[3:0] > `CPUAX_BCD_MAX);
			end
			cpuax_pkg::FM_NIB:
			begin
				// two's complement nibbles: x offset high, y offset low
				sign = value[7] | value[3];
			end
			default:
			begin
				bad = 1'b1;
			end
		endcase
	end

endmodule

// ==== rtl/cpuax_agu.sv ====
`include "cpuax_params.svh"

// How it works
// - all addresses formed and stepped are twenty bits wide
// - bank field drives address bits 19:16, register byte address bits 15:0
// - six four-bit bank fields held, one per access type
// - a byte is eight bits, a word sixteen bits
// - bit set/clear take byte or word; bit test takes only bytes
// - two's complement integers; packed signed nibbles only for multiply-accumulate offsets
// - 32-bit operands only for extended multiply/divide and long pair moves
// - packed decimal is two digits a byte; decimal operations take bytes only
// - 16-bit fraction: sign bit 15, range 8000 to 7fff
// - 32-bit fraction: sign bit 31, radix below it
// - 36-bit fixed point: sign bit 35, extension bits 34:31
// - memory is sixteen linear 64 KB banks reached by 20-bit address
// - a word is two consecutive bytes, normally at an even address
// - long operands are two consecutive words, accessed at first byte
// - instruction fetches always target word addresses
// - odd-address words and stack accesses are allowed, only slower
// - a misaligned word moves as two successive byte transfers
// - address bit 0 is driven low during every fetch
module cpuax_agu (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic req_valid, // access request
	output logic req_ready, // block can take a request
	input wire cpuax_pkg::cpuax_kind_t req_kind, // access type, picks the bank field
	input wire cpuax_pkg::cpuax_op_t req_op, // operation class
	input wire cpuax_pkg::cpuax_size_t req_size, // operand size
	input wire logic req_write, // 1 = store
	input wire logic [`CPUAX_OFS_W-1:0] req_addr, // register byte address
	input wire logic [`CPUAX_LONG_W-1:0] req_wdata, // store data, low aligned
	output logic rsp_valid, // access finished, one cycle
	output logic rsp_err, // operand size or access type illegal for the operation
	output logic [`CPUAX_LONG_W-1:0] rsp_rdata, // load data, low aligned
	input wire logic bank_we, // write one bank field
	input wire cpuax_pkg::cpuax_kind_t bank_sel, // which field
	input wire logic [`CPUAX_BANK_W-1:0] bank_val, // new field value
	output logic [`CPUAX_NBANK*`CPUAX_BANK_W-1:0] bank_q, // all six fields
	output logic [`CPUAX_ADDR_W-1:0] bus_addr, // 20-bit bus address
	output logic bus_byte, // 1 = byte transfer, 0 = word
	output logic bus_rd, // read strobe
	output logic bus_wr, // write strobe
	output logic [`CPUAX_WORD_W-1:0] bus_wdata, // write data
	input wire logic [`CPUAX_WORD_W-1:0] bus_rdata, // read data
	input wire logic bus_ack, // transfer done
	input wire cpuax_pkg::cpuax_fmt_t chk_fmt, // format under check
	input wire logic [`CPUAX_FIX_W-1:0] chk_value, // value under check
	output logic chk_sign, // value negative
	output logic chk_bad, // value out of range
	output logic chk_min // value is most negative fraction or fixed point code
);

	localparam cpuax_pkg::cpuax_regs_t RST = '{
		st: cpuax_pkg::ST_IDLE,
		banks: {`CPUAX_NBANK{`CPUAX_BANK_RST}},
		req_ready: 1'b1,
		default: '0
	};

	cpuax_pkg::cpuax_regs_t q;
	cpuax_pkg::cpuax_regs_t d;
	logic launch;
	logic [`CPUAX_ADDR_W-1:0] base;
	logic [`CPUAX_BYTE_W-1:0] got;
	logic f_sign;
	logic f_bad;
	logic f_min;
	logic take;

	// operand size legality by operation class
	function automatic logic op_legal(input cpuax_pkg::cpuax_op_t op,
		input cpuax_pkg::cpuax_size_t sz, input cpuax_pkg::cpuax_kind_t kind);
		logic ok;
		ok = 1'b0;
		case (op)
			cpuax_pkg::OP_PLAIN: ok = sz != cpuax_pkg::SZ_LONG;
			cpuax_pkg::OP_BITSC: ok = sz != cpuax_pkg::SZ_LONG;
			cpuax_pkg::OP_BITTST: ok = sz == cpuax_pkg::SZ_BYTE;
			cpuax_pkg::OP_BCD: ok = sz == cpuax_pkg::SZ_BYTE;
			cpuax_pkg::OP_MACOFF: ok = sz == cpuax_pkg::SZ_BYTE;
			cpuax_pkg::OP_LONG: ok = sz == cpuax_pkg::SZ_LONG;
			cpuax_pkg::OP_FETCH: ok = sz == cpuax_pkg::SZ_WORD;
			default: ok = 1'b0;
		endcase
		// only fetches use the program bank, and kinds 6 and 7 do not exist
		if ((op == cpuax_pkg::OP_FETCH) != (kind == cpuax_pkg::BK_PC))
			ok = 1'b0;
		if (kind > cpuax_pkg::BK_SP)
			ok = 1'b0;
		return ok;
	endfunction

	// bytes moved per operand size
	function automatic logic [2:0] nbytes(input cpuax_pkg::cpuax_size_t sz);
		case (sz)
			cpuax_pkg::SZ_BYTE: return 3'h1;
			cpuax_pkg::SZ_WORD: return 3'h2;
			default: return 3'h4;
		endcase
	endfunction

	// store data moved to the top so bytes leave most significant first
	function automatic logic [`CPUAX_LONG_W-1:0] wd_align(input cpuax_pkg::cpuax_size_t sz,
		input logic [`CPUAX_LONG_W-1:0] w);
		case (sz)
			cpuax_pkg::SZ_BYTE: return {w[7:0], 24'h00_0000};
			cpuax_pkg::SZ_WORD: return {w[15:0], 16'h0000};
			default: return w;
		endcase
	endfunction

	cpuax_fmt u_fmt (
		.fmt(chk_fmt),
		.value(chk_value),
		.sign(f_sign),
		.bad(f_bad),
		.is_min(f_min)
	);

	assign take = req_valid && q.req_ready;

	// request, transfer sequencing and response
	always_comb
	begin
		d = q;
		launch = 1'b0;
		base = '0;
		got = '0;
		d.rsp_valid = 1'b0;
		d.chk_sign = f_sign;
		d.chk_bad = f_bad;
		d.chk_min = f_min;
		// a new bank value only affects accesses formed after it
		if (bank_we && bank_sel <= cpuax_pkg::BK_SP)
			d.banks[bank_sel] = bank_val;
		case (q.st)
			cpuax_pkg::ST_IDLE:
			begin
				if (req_valid)
				begin
					if (req_kind <= cpuax_pkg::BK_SP)
						base = {q.banks[req_kind], req_addr};
					if (req_kind == cpuax_pkg::BK_PC)
						base[0] = 1'b0;
					if (!op_legal(req_op, req_size, req_kind))
					begin
						// refused before any bus activity
						d.rsp_valid = 1'b1;
						d.rsp_err = 1'b1;
						d.rsp_rdata = '0;
					end
					else
					begin
						d.addr = base;
						d.left = nbytes(req_size);
						d.wdat = wd_align(req_size, req_wdata);
						d.acc = '0;
						d.wr = req_write && (req_op != cpuax_pkg::OP_FETCH);
						d.fetch = req_op == cpuax_pkg::OP_FETCH;
						d.st = cpuax_pkg::ST_BUS;
						d.req_ready = 1'b0;
						launch = 1'b1;
					end
				end
			end
			cpuax_pkg::ST_BUS:
			begin
				if (bus_ack)
				begin
					if (q.bus_byte)
					begin
						// even byte rides the upper lane
						got = q.bus_addr[0] ? bus_rdata[7:0] : bus_rdata[15:8];
						d.acc = {q.acc[23:0], got};
						d.wdat = {q.wdat[23:0], 8'h00};
						d.addr = q.addr + 20'h0_0001;
						d.left = q.left - 3'h1;
					end
					else
					begin
						d.acc = {q.acc[15:0], bus_rdata};
						d.wdat = {q.wdat[15:0], 16'h0000};
						// linear carry into the bank bits, bank field untouched
						d.addr = q.addr + 20'h0_0002;
						d.left = q.left - 3'h2;
					end
					if (d.left == 3'h0)
					begin
						d.bus_rd = 1'b0;
						d.bus_wr = 1'b0;
						d.rsp_valid = 1'b1;
						d.rsp_err = 1'b0;
						d.rsp_rdata = d.acc;
						d.st = cpuax_pkg::ST_IDLE;
						d.req_ready = 1'b1;
					end
					else
						launch = 1'b1;
				end
			end
			default:
			begin
				d = RST;
			end
		endcase
		// odd address or a last lone byte forces a byte transfer
		if (launch)
		begin
			d.bus_addr = d.addr;
			d.bus_byte = d.addr[0] || (d.left == 3'h1);
			d.bus_rd = !d.wr;
			d.bus_wr = d.wr;
			if (d.bus_byte)
				d.bus_wdata = {2{d.wdat[31:24]}};
			else
				d.bus_wdata = d.wdat[31:16];
		end
	end

	// whole state in one register
	always_ff @(posedge clk)
	begin
		if (srst)
			q <= RST;
		else
			q <= d;
	end

	assign req_ready = q.req_ready;
	assign rsp_valid = q.rsp_valid;
	assign rsp_err = q.rsp_err;
	assign rsp_rdata = q.rsp_rdata;
	assign bank_q = q.banks;
	assign bus_addr = q.bus_addr;
	assign bus_byte = q.bus_byte;
	assign bus_rd = q.bus_rd;
	assign bus_wr = q.bus_wr;
	assign bus_wdata = q.bus_wdata;
	assign chk_sign = q.chk_sign;
	assign chk_bad = q.chk_bad;
	assign chk_min = q.chk_min;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// an accepted odd word of data; fetches are forced even and never split
	sequence s_odd_word;
		take && req_size == cpuax_pkg::SZ_WORD && req_addr[0]
			&& req_kind != cpuax_pkg::BK_PC && op_legal(req_op, req_size, req_kind);
	endsequence

	// first byte of a misaligned word acknowledged
	sequence s_first_byte_done;
		bus_ack && bus_byte && bus_addr[0] && q.left == 3'h2;
	endsequence

	// a request whose size or kind does not suit its operation
	sequence s_refused;
		take && !op_legal(req_op, req_size, req_kind);
	endsequence

	a_fetch_even: assert property ((bus_rd && q.fetch) |-> !bus_addr[0])
		else $error("fetch drove an odd address");
	a_split_first: assert property (s_odd_word |=> (bus_byte && bus_addr[0]))
		else $error("misaligned word did not start with a byte");
	a_split_second: assert property (s_first_byte_done |=> (bus_byte && !bus_addr[0]
		&& bus_addr == $past(bus_addr) + 20'h0_0001))
		else $error("second byte of split word wrong");
	a_addr_concat: assert property ((take && req_kind != cpuax_pkg::BK_PC
		&& op_legal(req_op, req_size, req_kind))
		|=> bus_addr == {$past(q.banks[req_kind]), $past(req_addr)})
		else $error("bank and byte address not joined");
	a_bit_test_byte: assert property ((take && req_op == cpuax_pkg::OP_BITTST
		&& req_size != cpuax_pkg::SZ_BYTE) |=> (rsp_valid && rsp_err))
		else $error("bit test on word not refused");
	a_bcd_byte: assert property ((take && req_op == cpuax_pkg::OP_BCD
		&& req_size != cpuax_pkg::SZ_BYTE) |=> (rsp_valid && rsp_err))
		else $error("decimal operation on word not refused");
	// a back-to-back request may answer in the very next cycle
	a_long_only: assert property ((take && req_op == cpuax_pkg::OP_PLAIN
		&& req_size == cpuax_pkg::SZ_LONG) |=> (rsp_valid && rsp_err
		##1 (!rsp_valid || $past(take))))
		else $error("long plain operand not refused");
	a_long_step: assert property ((bus_ack && !bus_byte && q.left == 3'h4)
		|=> (bus_addr == $past(bus_addr) + 20'h0_0002 && !bus_byte))
		else $error("second word of long not next word");
	a_word_order: assert property ((bus_ack && !bus_byte && q.left == 3'h2 && bus_rd)
		|=> (rsp_valid && rsp_rdata[15:0] == $past(bus_rdata)))
		else $error("word bytes out of order");
	a_frac_sign: assert property ((chk_fmt == cpuax_pkg::FM_FRAC16)
		|=> chk_sign == $past(chk_value[15]))
		else $error("fraction sign not bit 15");
	a_fix_sign: assert property ((chk_fmt == cpuax_pkg::FM_FIX36)
		|=> chk_sign == $past(chk_value[35]))
		else $error("fixed point sign not bit 35");

	// refused requests answer at once and never reach the bus
	a_refuse_quiet: assert property (s_refused |=> (rsp_valid && rsp_err
		&& rsp_rdata == 32'h0000_0000 && !bus_rd && !bus_wr))
		else $error("refused request reached the bus");
	a_word_even: assert property (((bus_rd || bus_wr) && !bus_byte) |-> !bus_addr[0])
		else $error("word transfer at an odd address");
	a_last_byte: assert property (((bus_rd || bus_wr) && q.left == 3'h1) |-> bus_byte)
		else $error("lone last byte sent as a word");
	a_byte_lanes: assert property ((bus_wr && bus_byte)
		|-> bus_wdata[15:8] == bus_wdata[7:0])
		else $error("byte store not on both lanes");

	// bank fields move only on a write to an existing field
	a_bank_hold: assert property (!bank_we |=> bank_q == $past(bank_q))
		else $error("bank field changed without a write");
	a_bank_bad_sel: assert property ((bank_we && bank_sel > cpuax_pkg::BK_SP)
		|=> bank_q == $past(bank_q))
		else $error("write to a missing bank field landed");
	a_bank_write: assert property ((bank_we && bank_sel <= cpuax_pkg::BK_SP)
		|=> q.banks[$past(bank_sel)] == $past(bank_val))
		else $error("bank field write lost");

	// format decode shows one cycle after the value
	a_frac_min: assert property ((chk_fmt == cpuax_pkg::FM_FRAC16
		&& chk_value[15:0] == `CPUAX_F16_MIN) |=> chk_min)
		else $error("minus one fraction not flagged");
	a_frac32_min: assert property ((chk_fmt == cpuax_pkg::FM_FRAC32
		&& chk_value[31:0] == `CPUAX_F32_MIN) |=> chk_min)
		else $error("minus one long fraction not flagged");
	a_fix_ext: assert property ((chk_fmt == cpuax_pkg::FM_FIX36
		&& chk_value[34:31] != {4{chk_value[35]}}) |=> chk_bad)
		else $error("extension bits in use not flagged");
	a_fix_min: assert property ((chk_fmt == cpuax_pkg::FM_FIX36
		&& chk_value == `CPUAX_FIX_MIN) |=> (chk_min && chk_sign))
		else $error("most negative fixed point not flagged");
	a_bcd_digit: assert property ((chk_fmt == cpuax_pkg::FM_BCD
		&& chk_value[3:0] > `CPUAX_BCD_MAX) |=> chk_bad)
		else $error("decimal digit above nine not flagged");
	a_nib_sign: assert property ((chk_fmt == cpuax_pkg::FM_NIB
		&& (chk_value[7] || chk_value[3])) |=> chk_sign)
		else $error("negative offset nibble not flagged");

endmodule

// ==== verification/cpuax_mem.sv ====
`include "cpuax_params.svh"

// memory model on the far side of the bus
module cpuax_mem (
	input wire logic clk, // system clock
	input wire logic [`CPUAX_ADDR_W-1:0] bus_addr, // 20-bit bus address
	input wire logic bus_byte, // 1 = byte transfer
	input wire logic bus_rd, // read strobe
	input wire logic bus_wr, // write strobe
	input wire logic [`CPUAX_WORD_W-1:0] bus_wdata, // write data
	output logic [`CPUAX_WORD_W-1:0] bus_rdata, // read data
	output logic bus_ack // transfer done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [logic [19:0]];
	int ack_delay = 0;
	int cnt = 0;
	logic [7:0] b0;
	logic [7:0] b1;

	// unwritten bytes read back as the inverted low address byte, zero only where that byte is ff
	function automatic logic [7:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : ~a[7:0];
	endfunction

	initial
	begin
		bus_ack = 1'b0;
		bus_rdata = 16'h5a5a;
	end

	// data lines toggle whenever no answer is due, so stale data never matches
	always @(posedge clk)
	begin
		if (bus_ack)
		begin
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata;
		end
		else if (bus_rd || bus_wr)
		begin
			if (cnt < ack_delay)
			begin
				cnt <= cnt + 1;
				bus_rdata <= ~bus_rdata;
			end
			else
			begin
				cnt <= 0;
				bus_ack <= 1'b1;
				if (bus_wr && !bus_byte)
				begin
					mem[bus_addr] = bus_wdata[15:8];
					mem[bus_addr + 20'h1] = bus_wdata[7:0];
				end
				else if (bus_wr)
					mem[bus_addr] = bus_addr[0] ? bus_wdata[7:0] : bus_wdata[15:8];
				b0 = rd(bus_addr);
				b1 = rd(bus_addr + 20'h1);
				if (!bus_byte)
					bus_rdata <= {b0, b1};
				else
					bus_rdata <= bus_addr[0] ? {~b0, b0} : {b0, ~b0};
			end
		end
		else
			bus_rdata <= ~bus_rdata;
	end
endmodule

// ==== verification/tb_top.sv ====
`include "cpuax_params.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, req_valid, req_ready, req_write, rsp_valid, rsp_err, bank_we;
	logic bus_byte, bus_rd, bus_wr, bus_ack, chk_sign, chk_bad, chk_min;
	cpuax_pkg::cpuax_kind_t req_kind, bank_sel;
	cpuax_pkg::cpuax_op_t req_op;
	cpuax_pkg::cpuax_size_t req_size;
	cpuax_pkg::cpuax_fmt_t chk_fmt;
	logic [15:0] req_addr, bus_wdata, bus_rdata;
	logic [31:0] req_wdata, rsp_rdata;
	logic [3:0] bank_val;
	logic [23:0] bank_q;
	logic [19:0] bus_addr;
	logic [35:0] chk_value;
	logic [20:0] xq [$];
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;

	cpuax_agu cpuax_agu_i (.clk, .srst, .req_valid, .req_ready, .req_kind, .req_op,
		.req_size, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_err, .rsp_rdata,
		.bank_we, .bank_sel, .bank_val, .bank_q, .bus_addr, .bus_byte, .bus_rd, .bus_wr,
		.bus_wdata, .bus_rdata, .bus_ack, .chk_fmt, .chk_value, .chk_sign, .chk_bad, .chk_min);
	cpuax_mem cpuax_mem_i (.clk, .bus_addr, .bus_byte, .bus_rd, .bus_wr, .bus_wdata,
		.bus_rdata, .bus_ack);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// log of every completed transfer as {byte, address}
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if ((bus_rd || bus_wr) && bus_ack === 1'b1)
			xq.push_back({bus_byte, bus_addr});
		if (cyc == 6000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one request, held for one cycle, then a bounded wait for the response
	task automatic req(input logic [2:0] k, input logic [2:0] o, input logic [1:0] s,
		input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(negedge clk);
		req_kind = cpuax_pkg::cpuax_kind_t'(k);
		req_op = cpuax_pkg::cpuax_op_t'(o);
		req_size = cpuax_pkg::cpuax_size_t'(s);
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		xq.delete();
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		chk(36'(n < 60), 36'h1);
	endtask

	// field k gets value k+3; a write to an unused selector must change nothing
	task automatic t_banks();
		chk(36'({req_ready, bus_rd, bus_wr, rsp_valid, bank_q}), {8'h0, 4'h8, 24'h0});
		for (int k = 0; k < 7; k++)
		begin
			@(negedge clk);
			bank_we = 1'b1;
			bank_sel = cpuax_pkg::cpuax_kind_t'(3'(k));
			bank_val = (k == 6) ? 4'hf : 4'(k + 3);
		end
		@(negedge clk);
		bank_we = 1'b0;
		@(negedge clk);
		chk(36'(bank_q), 36'h876543);
	endtask

	// aligned word read on x with a slow partner
	task automatic t_word();
		cpuax_mem_i.ack_delay = 3;
		cpuax_mem_i.mem[20'h40010] = 8'hab;
		cpuax_mem_i.mem[20'h40011] = 8'hcd;
		req(3'h1, 3'h0, 2'h1, 1'b0, 16'h0010, 32'h0);
		cpuax_mem_i.ack_delay = 0;
		chk(36'({rsp_err, rsp_rdata}), 36'h0000abcd);
		chk(36'(xq.size()), 36'h1);
		chk(36'(xq[0]), {15'h0, 1'b0, 20'h40010});
	endtask

	// odd word store and load on the stack bank split into two bytes
	task automatic t_odd();
		req(3'h5, 3'h0, 2'h1, 1'b1, 16'h0021, 32'h1234);
		chk(36'(xq.size()), 36'h2);
		chk(36'(xq[0]), 36'({1'b1, 20'h80021}));
		chk(36'(xq[1]), 36'({1'b1, 20'h80022}));
		chk(36'({cpuax_mem_i.mem[20'h80021], cpuax_mem_i.mem[20'h80022]}), 36'h1234);
		req(3'h5, 3'h0, 2'h1, 1'b0, 16'h0021, 32'h0);
		chk(36'({rsp_err, rsp_rdata}), 36'h00001234);
	endtask

	// long load as two words, most significant first
	task automatic t_long();
		for (int i = 0; i < 4; i++)
			cpuax_mem_i.mem[20'h50100 + 20'(i)] = 8'(8'h11 * (i + 1));
		req(3'h2, 3'h5, 2'h2, 1'b0, 16'h0100, 32'h0);
		chk(36'({rsp_err, rsp_rdata}), 36'h011223344);
		chk(36'(xq[0]), 36'({1'b0, 20'h50100}));
		chk(36'(xq[1]), 36'({1'b0, 20'h50102}));
	endtask

	// fetch at an odd byte address goes out word aligned; fetch off the pc is refused
	task automatic t_fetch();
		req(3'h4, 3'h6, 2'h1, 1'b0, 16'h0203, 32'h0);
		chk(36'({rsp_err, xq[0]}), 36'({1'b0, 1'b0, 20'h70202}));
		req(3'h1, 3'h6, 2'h1, 1'b0, 16'h0202, 32'h0);
		chk({rsp_err, 35'(xq.size())}, 36'h800000000);
	endtask

	// word read over the top of a bank carries into the bank bits
	task automatic t_cross();
		cpuax_mem_i.mem[20'h6ffff] = 8'h5e;
		cpuax_mem_i.mem[20'h70000] = 8'h7c;
		req(3'h3, 3'h0, 2'h1, 1'b0, 16'hffff, 32'h0);
		chk(36'({rsp_err, rsp_rdata}), 36'h00005e7c);
		chk(36'(xq[0]), 36'({1'b1, 20'h6ffff}));
		chk(36'(xq[1]), 36'({1'b1, 20'h70000}));
		chk(36'(bank_q), 36'h876543);
	endtask

	// operand size legality, row = {op, size, refused}
	task automatic t_legal();
		logic [5:0] tb [8] = '{6'o10, 6'o12, 6'o20, 6'o23, 6'o33, 6'o43, 6'o05, 6'o53};
		for (int i = 0; i < 8; i++)
		begin
			req(3'h0, tb[i][5:3], tb[i][2:1], 1'b0, 16'h0300, 32'h0);
			chk(36'(rsp_err), 36'(tb[i][0]));
			if (tb[i][0])
				chk({rsp_rdata, 4'(xq.size())}, 36'h0);
		end
	endtask

	// format decode, row = {fmt, value, expected sign bad min, compare mask}
	task automatic t_fmt();
		logic [44:0] ft [8] = '{{3'h2, 36'h8000, 6'o57}, {3'h2, 36'h7fff, 6'o07},
			{3'h3, 36'h80000000, 6'o57}, {3'h4, 36'h800000000, 6'o77},
			{3'h4, 36'h080000000, 6'o27}, {3'h5, 36'h9a, 6'o22},
			{3'h5, 36'h99, 6'o02}, {3'h6, 36'h08, 6'o44}};
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk);
			chk_fmt = cpuax_pkg::cpuax_fmt_t'(ft[i][44:42]);
			chk_value = ft[i][41:6];
			@(negedge clk);
			chk(36'({chk_sign, chk_bad, chk_min} & ft[i][2:0]), 36'(ft[i][5:3]));
		end
	endtask

	initial
	begin
		srst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		bank_we = 1'b0;
		req_kind = cpuax_pkg::BK_EXT;
		bank_sel = cpuax_pkg::BK_EXT;
		req_op = cpuax_pkg::OP_PLAIN;
		req_size = cpuax_pkg::SZ_BYTE;
		chk_fmt = cpuax_pkg::FM_INT8;
		req_addr = 16'h0;
		req_wdata = 32'h0;
		bank_val = 4'h0;
		chk_value = 36'h0;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		t_banks();
		t_word();
		t_odd();
		t_long();
		t_fetch();
		t_cross();
		t_legal();
		t_fmt();
		finish_test();
	end
endmodule
